// ==== dv/ebm_ext_dev.sv ====
// model of the outside world on the port k pins
`timescale 1ns/1ps
module ebm_ext_dev (
    // clock
    input wire logic clk_i,
    // device side of the pins
    input wire logic [7:0] port_k_o,
    input wire logic [7:0] port_k_oe_o,
    // levels seen back on the pins
    output logic [7:0] pin_o
);
    logic [7:0] pat_q = 8'h5a;
    // released pins 7..1 toggle every cycle so a stale level never passes for a value; released pin 0 stays low
    always_ff @(posedge clk_i)
        pat_q <= ~pat_q ^ 8'h01;
    assign pin_o = (port_k_o & port_k_oe_o) | (pat_q & ~port_k_oe_o);
endmodule

// ==== dv/ebm_top_chk.sv ====
// assertions on the ports of the bus mode and port control block
`timescale 1ns/1ps
module ebm_top_chk #(
    parameter int NUM_PORTS = 8
) (
    // clock, reset and register bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic err_o,
    // chip control and ports
    input wire logic secure_i,
    input wire logic register_map_en_i,
    input wire logic [NUM_PORTS*8-1:0] port_dir_i,
    input wire logic [NUM_PORTS*8-1:0] pull_en_o,
    input wire logic [7:0] port_k_oe_o,
    input wire logic ext_echo_o,
    input wire logic [2:0] mode_o,
    // internal access and its external pattern
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic acc_word_i,
    input wire logic acc_ram_i,
    input wire logic [15:0] ram_word_i,
    input wire logic [15:0] ext_data_o,
    input wire logic low_byte_strobe_n_o,
    input wire logic address_bit_zero_o,
    input wire logic read_not_write_o,
    input wire logic [2:0] access_type_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic tk;
    logic pull_ok;
    // a request the slave takes at this edge
    assign tk = cyc_i && stb_i && !ack_o && !err_o;
    // an enabled port pulls exactly its input pins
    always_comb
    begin
        pull_ok = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++)
            if (pull_en_o[p*8+:8] != 8'h00 && pull_en_o[p*8+:8] != ~port_dir_i[p*8+:8])
                pull_ok = 1'b0;
    end
    sequence s_mw;
        tk && we_i && adr_i == ebm_pkg::ADDR_MODE;
    endsequence
    sequence s_dw;
        tk && we_i && adr_i == ebm_pkg::ADDR_PORT_K_DIR && register_map_en_i;
    endsequence
    sequence s_mis;
        acc_valid_i && acc_word_i && acc_ram_i && acc_addr_i[0];
    endsequence
    property p_sec;
        s_mw ##0 secure_i |=> $stable(mode_o);
    endproperty
    property p_lock;
        s_mw ##0 (mode_o[0] || mode_o == 3'h6 || dat_i[2:0] == 3'h6) |=> $stable(mode_o);
    endproperty
    property p_top;
        mode_o == 3'h4 |=> mode_o[2];
    endproperty
    property p_pull;
        pull_ok;
    endproperty
    property p_map;
        tk && adr_i == ebm_pkg::ADDR_PULL_SELECT |=> ack_o == $past(register_map_en_i) && err_o != ack_o;
    endproperty
    property p_dir;
        s_dw |=> ext_echo_o || port_k_oe_o == $past(dat_i[7:0]);
    endproperty
    property p_echo;
        ext_echo_o |-> ack_o && $stable(port_k_oe_o);
    endproperty
    property p_byte;
        acc_valid_i && !acc_word_i |=> low_byte_strobe_n_o != $past(acc_addr_i[0])
            && address_bit_zero_o == $past(acc_addr_i[0]) && read_not_write_o != $past(acc_write_i);
    endproperty
    property p_mis;
        s_mis |=> low_byte_strobe_n_o && address_bit_zero_o && access_type_o == ebm_pkg::ACC_MISALIGNED
            && ext_data_o == {$past(ram_word_i[7:0]), $past(ram_word_i[15:8])};
    endproperty
    a_sec: assert property (p_sec) else $error("mode moved while secured");
    a_lock: assert property (p_lock) else $error("locked mode moved");
    a_top: assert property (p_top) else $error("top mode bit left normal");
    a_pull: assert property (p_pull) else $error("pull on an output pin");
    a_map: assert property (p_map) else $error("pull select answer wrong");
    a_dir: assert property (p_dir) else $error("direction not written");
    a_echo: assert property (p_echo) else $error("echoed access changed direction");
    a_byte: assert property (p_byte) else $error("byte access pattern wrong");
    a_mis: assert property (p_mis) else $error("misaligned word pattern wrong");
endmodule
bind ebm_top ebm_top_chk #(.NUM_PORTS(NUM_PORTS)) i_chk (.*);

// ==== dv/external_bus_mode_port_ctrl_bench.sv ====
// self-checking bench for the bus mode and port control block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module external_bus_mode_port_ctrl_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, secure_i = 1'b0, map_en_i = 1'b1;
    logic acc_valid_i = 1'b0, acc_write_i = 1'b0, acc_word_i = 1'b0, acc_ram_i = 1'b0;
    logic ack_o, err_o, ext_echo_o, lsn, ab0, rnw, v;
    logic [9:0] adr_i = 10'h000;
    logic [31:0] dat_i = 32'h0, dat_o, r, d;
    logic [15:0] acc_addr_i = 16'h0, ram_word_i = 16'h0, ext_data_o;
    logic [7:0] kdat = 8'h00, kpin, k_o, k_oe;
    logic [63:0] dir_i = 64'h0, pull_en_o, pexp;
    logic [2:0] acc_type_o, mode_o;
    logic [34:0] q[$];
    logic [22:0] aq[$];
    logic [34:0] n;
    logic [22:0] an;
    // mode writes as {secure, data}; the last keeps emulation set while trying a locked move
    logic [8:0] mt [9] = '{9'h103, 9'h006, 9'h002, 9'h006, 9'h004, 9'h105, 9'h006, 9'h085, 9'h087};
    logic [2:0] me [9] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5};
    int err_count = 0, num_checks = 0, seed = 32'h4442, i;
    initial forever #10 clk_i = ~clk_i;
    ebm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .strap_mode_i(3'h0),
        .secure_i(secure_i), .register_map_en_i(map_en_i), .port_dir_i(dir_i), .pull_en_o(pull_en_o),
        .port_k_data_i(kdat), .port_k_pin_i(kpin), .port_k_o(k_o), .port_k_oe_o(k_oe), .ext_echo_o(ext_echo_o),
        .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i), .acc_word_i(acc_word_i),
        .acc_ram_i(acc_ram_i), .ram_word_i(ram_word_i), .ext_data_o(ext_data_o), .low_byte_strobe_n_o(lsn),
        .address_bit_zero_o(ab0), .read_not_write_o(rnw), .access_type_o(acc_type_o), .mode_o(mode_o));
    ebm_ext_dev i_dev (.clk_i(clk_i), .port_k_o(k_o), .port_k_oe_o(k_oe), .pin_o(kpin));
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one classic cycle; note is {check data, echo, err, data}
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] dd, input logic [34:0] e);
        int k;
        q.push_back(e);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= dd;
        for (k = 0; k < 20 && !(ack_o || err_o); k++)
            @(posedge clk_i);
        if (k == 20)
        begin
            err_count++;
            summarize();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // internal access; pins expected one cycle later
    task automatic acc(input logic [31:0] x);
        logic mis;
        mis = x[3] && x[4] && x[16];
        if (mis)
            aq.push_back({3'b111, !x[2], ebm_pkg::ACC_MISALIGNED, x[7:0], x[15:8]});
        else if (x[3] && !x[16])
            aq.push_back({3'b000, !x[2], ebm_pkg::ACC_WORD, 16'h0000});
        else
            aq.push_back({1'b0, !x[16], x[16], !x[2], 1'b0, x[2], x[16], 16'h0000});
        acc_valid_i <= 1'b1;
        acc_write_i <= x[2];
        acc_word_i <= x[3];
        acc_ram_i <= x[4];
        acc_addr_i <= x[31:16];
        ram_word_i <= x[15:0];
        @(posedge clk_i);
    endtask
    // answers are matched against the oldest note
    always @(posedge clk_i)
    begin
        v = acc_valid_i;
        #1;
        if (ack_o || err_o)
        begin
            n = q.pop_front();
            `CHK({ext_echo_o, err_o, n[34] ? dat_o : 32'h0}, n[33:0])
        end
        if (v)
        begin
            an = aq.pop_front();
            `CHK({lsn, ab0, rnw, acc_type_o, an[22] ? ext_data_o : 16'h0000}, an[21:0])
        end
    end
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        wb(1'b0, ebm_pkg::ADDR_PULL_SELECT, 32'h0, {3'b100, 24'h0, ebm_pkg::RST_PULL_SELECT});
        wb(1'b0, ebm_pkg::ADDR_PORT_K_DIR, 32'h0, {3'b100, 24'h0, ebm_pkg::RST_PORT_K_DIR});
        r = $random(seed);
        d = $random(seed);
        wb(1'b1, ebm_pkg::ADDR_PULL_SELECT, r, 35'h0);
        dir_i <= {$random(seed), $random(seed)};
        kdat <= d[15:8];
        @(posedge clk_i);
        for (i = 0; i < 8; i++)
            pexp[i*8+:8] = {8{r[i]}} & ~dir_i[i*8+:8];
        `CHK(pull_en_o, pexp)
        wb(1'b0, ebm_pkg::ADDR_PULL_SELECT, 32'h0, {3'b100, 24'h0, r[7:0]});
        map_en_i <= 1'b0;
        wb(1'b0, ebm_pkg::ADDR_PULL_SELECT, 32'h0, {3'b001, 32'h0});
        map_en_i <= 1'b1;
        wb(1'b1, 10'h3fc, r, {3'b001, 32'h0});
        wb(1'b1, ebm_pkg::ADDR_PORT_K_DIR, d, 35'h0);
        wb(1'b0, ebm_pkg::ADDR_PORT_K_DIR, 32'h0, {3'b100, 24'h0, d[7:0]});
        `CHK({k_oe, kpin & d[7:0]}, {d[7:0], d[15:8] & d[7:0]})
        for (i = 0; i < 9; i++)
        begin
            secure_i <= mt[i][8];
            wb(1'b1, ebm_pkg::ADDR_MODE, {24'h0, mt[i][7:0]}, 35'h0);
            `CHK(mode_o, me[i])
        end
        wb(1'b0, ebm_pkg::ADDR_MODE, 32'h0, {3'b100, 24'h0, 8'h85});
        secure_i <= 1'b1;
        wb(1'b0, ebm_pkg::ADDR_STATUS, 32'h0, {3'b100, 29'h0, 3'b100});
        secure_i <= 1'b0;
        wb(1'b1, ebm_pkg::ADDR_PORT_K_DIR, ~d, {3'b010, 32'h0});
        wb(1'b0, ebm_pkg::ADDR_PORT_K_DIR, 32'h0, {3'b110, 32'h0});
        `CHK(k_oe, d[7:0])
        for (i = 0; i < 24; i++)
            acc($random(seed));
        acc_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        summarize();
    end
endmodule

// ==== rtl/ebm_access_decode.sv ====
// encoding of an internal access into external strobe, address bit, direction and access type
`timescale 1ns/1ps
module ebm_access_decode (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // internal access
    input wire logic valid_i,
    input wire logic write_i,
    input wire logic [15:0] addr_i,
    input wire logic word_i,
    input wire logic ram_i,
    // external signals
    output logic low_byte_strobe_n_o,
    output logic address_bit_zero_o,
    output logic read_not_write_o,
    output logic [2:0] access_type_o
);

    typedef struct packed {
        logic low_byte_strobe_n_n;
        logic ab0;
        logic rnw;
        logic [2:0] acc;
    } ebm_dec_state_t;

    ebm_dec_state_t s_q;
    ebm_dec_state_t s_d;
    logic mis;

    // strobe encoding; misaligned words only for internal ram
    always_comb
    begin
        s_d = s_q;
        mis = word_i && addr_i[0] && ram_i;
        if (valid_i)
        begin
            s_d.rnw = !write_i;
            s_d.ab0 = addr_i[0];
            if (mis)
            begin
                s_d.low_byte_strobe_n_n = 1'b1;
                s_d.acc = ebm_pkg::ACC_MISALIGNED;
            end
            else if (word_i && !addr_i[0])
            begin
                s_d.low_byte_strobe_n_n = 1'b0;
                s_d.acc = ebm_pkg::ACC_WORD;
            end
            else
            begin
                // byte: even drives strobe high, odd drives it low
                s_d.low_byte_strobe_n_n = !addr_i[0];
                s_d.acc = {1'b0, write_i, addr_i[0]};
            end
        end
    end

    // output register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '{low_byte_strobe_n_n: 1'b1, ab0: 1'b0, rnw: 1'b1, acc: 3'h0};
        else
            s_q <= s_d;
    end

    assign low_byte_strobe_n_o = s_q.low_byte_strobe_n_n;
    assign address_bit_zero_o = s_q.ab0;
    assign read_not_write_o = s_q.rnw;
    assign access_type_o = s_q.acc;

endmodule

// ==== rtl/ebm_mode_guard.sv ====
// mode bit write qualification and write-once tracking
`timescale 1ns/1ps
module ebm_mode_guard (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic [2:0] strap_mode_i,
    input wire logic secure_i,
    input wire logic wr_i,
    input wire logic [2:0] wr_mode_i,
    // state
    output logic [2:0] mode_o,
    output logic once_left_o
);

    typedef struct packed {
        logic [2:0] mode;
        logic once_left;
        logic strapped;
    } ebm_guard_state_t;

    ebm_guard_state_t s_q;
    ebm_guard_state_t s_d;
    logic special;
    logic accept;

    // decide whether a mode write may land
    always_comb
    begin
        s_d = s_q;
        special = (s_q.mode == ebm_pkg::MODE_SPECIAL_SINGLE) || (s_q.mode == ebm_pkg::MODE_SPECIAL_TEST);
        accept = 1'b0;
        if (wr_i && !secure_i)
        begin
            if (special && wr_mode_i != ebm_pkg::MODE_SPECIAL_PERIPH)
                accept = 1'b1;
            else if (s_q.mode == ebm_pkg::MODE_NORMAL_SINGLE && s_q.once_left
                     && wr_mode_i[2] && wr_mode_i != ebm_pkg::MODE_SPECIAL_PERIPH)
                accept = 1'b1;
        end
        // strap caught on the first clocked cycle after reset release
        if (!s_q.strapped)
        begin
            s_d.strapped = 1'b1;
            s_d.mode = strap_mode_i;
            s_d.once_left = 1'b1;
        end
        else if (accept)
        begin
            s_d.mode = wr_mode_i;
            // leaving special for normal single keeps one write; otherwise spent
            s_d.once_left = special && (wr_mode_i == ebm_pkg::MODE_NORMAL_SINGLE);
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign mode_o = s_q.mode;
    assign once_left_o = s_q.once_left;

endmodule

// ==== rtl/ebm_top.sv ====
// external bus mode and port control with wishbone register slave
//
// Overview of operation
// - in special single-chip and special test modes all mode bits may be written except to the peripheral code.
// - in normal single-chip mode the top mode bit never changes and the lower two change once, never to 110.
// - while secured every mode write is ignored.
// - a move from special into normal single-chip leaves one write; any other move leaves none.
// - pulls enable per port and act only on pins of that port that are inputs.
// - the pull select register is readable and writable whenever it is mapped.
// - each port k direction bit makes its pin an input when clear and an output when set.
// - with port k emulation set in peripheral or expanded modes the direction register goes external.
// - strobe high with bit zero low is an even byte, strobe low with bit zero high odd; r/w high reads.
// - strobe high with bit zero high occurs only for misaligned internal ram word accesses.
// - a misaligned ram word puts the addressed byte low and the next byte high on the data bus.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ebm_top #(
    parameter int NUM_PORTS = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // chip control
    input wire logic [2:0] strap_mode_i,
    input wire logic secure_i,
    input wire logic register_map_en_i,
    // port pin direction per port (1 = output)
    input wire logic [NUM_PORTS*8-1:0] port_dir_i,
    output logic [NUM_PORTS*8-1:0] pull_en_o,
    // port k pin control
    input wire logic [7:0] port_k_data_i,
    input wire logic [7:0] port_k_pin_i,
    output logic [7:0] port_k_o,
    output logic [7:0] port_k_oe_o,
    // echoed external register access
    output logic ext_echo_o,
    // internal access to be signalled externally
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic acc_word_i,
    input wire logic acc_ram_i,
    input wire logic [15:0] ram_word_i,
    output logic [15:0] ext_data_o,
    output logic low_byte_strobe_n_o,
    output logic address_bit_zero_o,
    output logic read_not_write_o,
    output logic [2:0] access_type_o,
    // mode state
    output logic [2:0] mode_o
);

    typedef struct packed {
        logic [7:0] pull;
        logic [7:0] kdir;
        logic port_k_emulation_enable;
        logic ack;
        logic err;
        logic echo;
        logic [31:0] rdat;
        logic [15:0] xdat;
    } ebm_top_state_t;

    ebm_top_state_t s_q;
    ebm_top_state_t s_d;
    logic [2:0] mode;
    logic once_left;
    logic req;
    logic mode_wr;
    logic kdir_mapped;
    logic hit_pull;
    logic hit_kdir;
    logic hit_mode;
    logic hit_stat;
    logic [7:0] port_k_in;

    // mode bits and their write protection
    ebm_mode_guard u_guard (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .strap_mode_i(strap_mode_i),
        .secure_i(secure_i),
        .wr_i(mode_wr),
        .wr_mode_i(dat_i[ebm_pkg::MODE_BITS_LSB +: 3]),
        .mode_o(mode),
        .once_left_o(once_left)
    );

    // external access type encoding
    ebm_access_decode u_dec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .valid_i(acc_valid_i),
        .write_i(acc_write_i),
        .addr_i(acc_addr_i),
        .word_i(acc_word_i),
        .ram_i(acc_ram_i),
        .low_byte_strobe_n_o(low_byte_strobe_n_o),
        .address_bit_zero_o(address_bit_zero_o),
        .read_not_write_o(read_not_write_o),
        .access_type_o(access_type_o)
    );

    // address decode; direction register leaves the map in emulated expanded modes
    always_comb
    begin
        req = cyc_i && stb_i && !s_q.ack && !s_q.err;
        kdir_mapped = !(s_q.port_k_emulation_enable && (mode == ebm_pkg::MODE_SPECIAL_PERIPH || mode[0]));
        hit_pull = register_map_en_i && adr_i == ebm_pkg::ADDR_PULL_SELECT;
        hit_kdir = register_map_en_i && kdir_mapped && adr_i == ebm_pkg::ADDR_PORT_K_DIR;
        hit_mode = adr_i == ebm_pkg::ADDR_MODE;
        hit_stat = adr_i == ebm_pkg::ADDR_STATUS;
        mode_wr = req && we_i && sel_i[0] && hit_mode;
    end

    // register file and bus answer, one wait-free cycle
    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.echo = 1'b0;
        if (req)
        begin
            if (hit_pull || hit_kdir || hit_mode || hit_stat)
                s_d.ack = 1'b1;
            else if (register_map_en_i && adr_i == ebm_pkg::ADDR_PORT_K_DIR)
            begin
                // unmapped direction access goes out on the external bus
                s_d.ack = 1'b1;
                s_d.echo = 1'b1;
            end
            else
                s_d.err = 1'b1;
            if (we_i && sel_i[0])
            begin
                if (hit_pull)
                    s_d.pull = dat_i[7:0];
                if (hit_kdir)
                    s_d.kdir = dat_i[7:0];
                if (hit_mode && !secure_i)
                    s_d.port_k_emulation_enable = dat_i[ebm_pkg::MODE_EMK_BIT];
            end
            s_d.rdat = 32'h0000_0000;
            if (!we_i)
            begin
                if (hit_pull)
                    s_d.rdat = {24'h00_0000, s_q.pull};
                else if (hit_kdir)
                    s_d.rdat = {24'h00_0000, s_q.kdir};
                else if (hit_mode)
                    s_d.rdat = {24'h00_0000, s_q.port_k_emulation_enable, 4'h0, mode};
                else if (hit_stat)
                    s_d.rdat = {29'h0000_0000, secure_i, once_left, kdir_mapped};
            end
        end
        // misaligned ram word: addressed byte low, next byte high
        if (acc_valid_i && acc_word_i && acc_addr_i[0] && acc_ram_i)
            s_d.xdat = {ram_word_i[7:0], ram_word_i[15:8]};
        else if (acc_valid_i)
            s_d.xdat = ram_word_i;
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '{pull: ebm_pkg::RST_PULL_SELECT, kdir: ebm_pkg::RST_PORT_K_DIR, default: '0};
        else
            s_q <= s_d;
    end

    // pulls per port, only on input pins
    generate
        for (genvar p = 0; p < NUM_PORTS; p++)
        begin : g_pull
            assign pull_en_o[p*8 +: 8] = {8{s_q.pull[p]}} & ~port_dir_i[p*8 +: 8];
        end
    endgenerate

    // port k drive: set bit outputs, clear bit is high-impedance input
    assign port_k_oe_o = s_q.kdir;
    assign port_k_o = port_k_data_i;
    assign port_k_in = port_k_pin_i;

    assign dat_o = s_q.rdat;
    assign ack_o = s_q.ack;
    assign err_o = s_q.err;
    assign ext_echo_o = s_q.echo;
    assign ext_data_o = s_q.xdat;
    assign mode_o = mode;

endmodule

// ==== shared/ebm_pkg.sv ====
// package for the external bus mode and port control block
package ebm_pkg;

    // register word indices; the bus byte address is the index times four
    localparam logic [7:0] IDX_PULL_SELECT = 8'h0c;
    localparam logic [7:0] IDX_PORT_K_DIR = 8'h33;
    localparam logic [7:0] IDX_MODE = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    localparam logic [9:0] ADDR_PULL_SELECT = {IDX_PULL_SELECT, 2'b00};
    localparam logic [9:0] ADDR_PORT_K_DIR = {IDX_PORT_K_DIR, 2'b00};
    localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // mode register fields
    localparam int MODE_BITS_LSB = 0;
    localparam int MODE_EMK_BIT = 7;

    // reset values
    localparam logic [7:0] RST_PULL_SELECT = 8'h00;
    localparam logic [7:0] RST_PORT_K_DIR = 8'h00;

    // operating modes, encoded as mode_select_bit2..bit0
    typedef enum logic [2:0] {
        MODE_SPECIAL_SINGLE = 3'h0,
        MODE_EMUL_NARROW = 3'h1,
        MODE_SPECIAL_TEST = 3'h2,
        MODE_EMUL_WIDE = 3'h3,
        MODE_NORMAL_SINGLE = 3'h4,
        MODE_NORMAL_EXP_NARROW = 3'h5,
        MODE_SPECIAL_PERIPH = 3'h6,
        MODE_NORMAL_EXP_WIDE = 3'h7
    } ebm_mode_t;

    // external access types
    typedef enum logic [2:0] {
        ACC_READ_EVEN = 3'h0,
        ACC_READ_ODD = 3'h1,
        ACC_WRITE_EVEN = 3'h2,
        ACC_WRITE_ODD = 3'h3,
        ACC_WORD = 3'h4,
        ACC_MISALIGNED = 3'h5
    } ebm_access_t;

endpackage
